// ===== verilog/synth_control_registers.sv
`timescale 1ns/10ps
module synth_control_registers #(
   parameter int TIMER_W = 9
) (
   // Clock and reset
   input  wire logic        i_clk_sys,
   input  wire logic        i_resetn,
   // Completed serial words
   input  wire logic [23:0] i_word,
   input  wire logic        i_word_load,
   // Loop timing and monitor sources
   input  wire logic        i_pd_tick,
   input  wire logic        i_ref_div_out,
   input  wire logic        i_int_div_out,
   input  wire logic        i_lock_detect,
   // Loop function controls
   output logic             o_pump_ground,
   output logic             o_pd_polarity_pos,
   // Power controls
   output logic             o_pll_powered_down,
   output logic             o_amp_powerdown,
   output logic             o_pump_powerdown,
   output logic             o_pump_tristate,
   output logic             o_divider_hold,
   output logic             o_counter_reset,
   output logic             o_lock_detect_reset,
   // Fast lock
   output logic             o_divider_load,
   output logic [2:0]       o_pump_current_step,
   output logic             o_switch_ab_closed,
   output logic             o_switch_c_closed,
   // Modes and monitor
   output logic             o_dither_en,
   output logic             o_lock_thresh_10ns,
   output logic             o_monitor_output
);

   // Select field of a word, shared by all decodes
   function automatic logic [2:0] word_select(input logic [23:0] w);
      word_select = w[synth_ctrl_pkg::SEL_LSB +: 3];
   endfunction

   logic                 wr_loop;
   logic                 wr_fastlock;
   logic                 wr_power;
   logic                 wr_mode;
   logic                 wr_channel;
   logic [1:0]           timer_sel;
   logic [TIMER_W-1:0]   timer_val;
   logic [TIMER_W-1:0]   load_val [synth_ctrl_pkg::NUM_TIMERS];
   logic [2:0]           tmr_run;
   logic [4:0]           pd_bits;
   logic [3:0]           mon_sel;
   logic                 seen_phase;
   logic                 seen_modulus;
   logic                 apply_pending;
   logic                 apply;
   logic [1:0]           quarter_cnt;
   logic                 quarter_tick;

   // Word decode
   assign wr_loop     = i_word_load && word_select(i_word) == synth_ctrl_pkg::SEL_LOOP;
   assign wr_fastlock = i_word_load
                        && word_select(i_word) == synth_ctrl_pkg::SEL_FASTLOCK;
   assign wr_power    = i_word_load && word_select(i_word) == synth_ctrl_pkg::SEL_POWER;
   assign wr_mode     = i_word_load && word_select(i_word) == synth_ctrl_pkg::SEL_MODE;
   assign wr_channel  = i_word_load
                        && word_select(i_word) == synth_ctrl_pkg::SEL_CHANNEL;
   assign timer_sel   = i_word[synth_ctrl_pkg::TIMER_SEL_LSB +: 2];
   assign timer_val   = i_word[synth_ctrl_pkg::TIMER_VAL_LSB +: TIMER_W];
   assign apply       = apply_pending && i_pd_tick;
   assign quarter_tick = i_pd_tick && quarter_cnt == 2'(synth_ctrl_pkg::PD_PER_TICK - 1);

   // Loop function bits; reserved bits are the host's business
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         o_pump_ground     <= 1'b1;
         o_pd_polarity_pos <= 1'b1;
      end else if (wr_loop) begin
         o_pump_ground     <= !i_word[synth_ctrl_pkg::PUMP_GND_N_BIT];
         o_pd_polarity_pos <= i_word[synth_ctrl_pkg::POLARITY_BIT];
      end
   end

   // Timer load values, one write per timer
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         for (int k = 0; k < synth_ctrl_pkg::NUM_TIMERS; k++) begin
            load_val[k] <= TIMER_W'(synth_ctrl_pkg::TIMER_RESET);
         end
      end else if (wr_fastlock) begin
         case (timer_sel)
            synth_ctrl_pkg::TSEL_PUMP:      load_val[synth_ctrl_pkg::TMR_PUMP]  <= timer_val;
            synth_ctrl_pkg::TSEL_SWITCH_AB: load_val[synth_ctrl_pkg::TMR_SW_AB] <= timer_val;
            synth_ctrl_pkg::TSEL_SWITCH_C:  load_val[synth_ctrl_pkg::TMR_SW_C]  <= timer_val;
            default: ;
         endcase
      end
   end

   // Power-down bits; only amp changes when both bits agree
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         pd_bits         <= synth_ctrl_pkg::PD_RESET;
         o_amp_powerdown <= 1'b1;
      end else if (wr_power) begin
         pd_bits <= i_word[synth_ctrl_pkg::CNT_RESET_BIT +: 5];
         if (i_word[synth_ctrl_pkg::AMP_PD_HI_BIT] && i_word[synth_ctrl_pkg::AMP_PD_LO_BIT]) begin
            o_amp_powerdown <= 1'b1;
         end else if (!i_word[synth_ctrl_pkg::AMP_PD_HI_BIT]
                      && !i_word[synth_ctrl_pkg::AMP_PD_LO_BIT]) begin
            o_amp_powerdown <= 1'b0;
         end
      end
   end

   // Pump and divider controls follow the power-down bits
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         o_pump_powerdown    <= 1'b1;
         o_pump_tristate     <= 1'b1;
         o_divider_hold      <= 1'b1;
         o_counter_reset     <= 1'b1;
         o_lock_detect_reset <= 1'b1;
      end else begin
         o_pump_powerdown    <= pd_bits[synth_ctrl_pkg::PUMP_PD_BIT - 3];
         o_pump_tristate     <= pd_bits[synth_ctrl_pkg::TRISTATE_BIT - 3]
                                || pd_bits[synth_ctrl_pkg::PUMP_PD_BIT - 3];
         o_divider_hold      <= pd_bits[synth_ctrl_pkg::PUMP_PD_BIT - 3];
         o_counter_reset     <= pd_bits[synth_ctrl_pkg::CNT_RESET_BIT - 3];
         o_lock_detect_reset <= pd_bits[synth_ctrl_pkg::PUMP_PD_BIT - 3];
      end
   end

   // Power-up hold: leave only after the full initial word set
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         seen_phase         <= 1'b0;
         seen_modulus       <= 1'b0;
         o_pll_powered_down <= 1'b1;
      end else begin
         if (i_word_load && word_select(i_word) == synth_ctrl_pkg::SEL_PHASE) begin
            seen_phase <= 1'b1;
         end
         if (i_word_load && word_select(i_word) == synth_ctrl_pkg::SEL_MODULUS) begin
            seen_modulus <= 1'b1;
         end
         if (wr_channel && seen_phase && seen_modulus
             && !pd_bits[synth_ctrl_pkg::PUMP_PD_BIT - 3]) begin
            o_pll_powered_down <= 1'b0;
         end
      end
   end

   // Channel write waits for the next detector cycle
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         apply_pending  <= 1'b0;
         o_divider_load <= 1'b0;
      end else begin
         apply_pending  <= wr_channel || (apply_pending && !i_pd_tick);
         o_divider_load <= apply;
      end
   end

   // Quarter-rate divider, realigned at each apply
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         quarter_cnt <= 2'h0;
      end else if (apply) begin
         quarter_cnt <= 2'h0;
      end else if (i_pd_tick) begin
         quarter_cnt <= quarter_cnt + 2'h1;
      end
   end

   // Three timeout counters, all started together
   generate
      for (genvar g = 0; g < synth_ctrl_pkg::NUM_TIMERS; g++) begin : g_timer
         fastlock_timeout #(
            .WIDTH      (TIMER_W)
         ) u_timer (
            .i_clk_sys  (i_clk_sys),
            .i_resetn   (i_resetn),
            .i_start    (apply),
            .i_tick     (quarter_tick),
            .i_load_val (load_val[g]),
            .o_running  (tmr_run[g])
         );
      end
   endgenerate

   // Switches track their counters
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         o_switch_ab_closed <= 1'b0;
         o_switch_c_closed  <= 1'b0;
      end else begin
         o_switch_ab_closed <= apply || tmr_run[synth_ctrl_pkg::TMR_SW_AB];
         o_switch_c_closed  <= apply || tmr_run[synth_ctrl_pkg::TMR_SW_C];
      end
   end

   // Pump current: step 6 is 64x, each quarter tick after expiry halves it
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         o_pump_current_step <= 3'h0;
      end else if (apply) begin
         o_pump_current_step <= synth_ctrl_pkg::PUMP_STEP_MAX;
      end else if (!tmr_run[synth_ctrl_pkg::TMR_PUMP] && quarter_tick
                   && o_pump_current_step != 3'h0) begin
         o_pump_current_step <= o_pump_current_step - 3'h1;
      end
   end

   // Mode codes; unlisted codes leave the modes alone
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         o_dither_en        <= 1'b0;
         o_lock_thresh_10ns <= 1'b0;
         mon_sel            <= synth_ctrl_pkg::MON_RESET;
      end else if (wr_mode) begin
         mon_sel <= i_word[synth_ctrl_pkg::MON_LSB +: 4];
         case (i_word[synth_ctrl_pkg::MODE_LSB +: 4])
            synth_ctrl_pkg::MODE_DEFAULT: begin
               o_dither_en        <= 1'b0;
               o_lock_thresh_10ns <= 1'b0;
            end
            synth_ctrl_pkg::MODE_DITHER_ON: o_dither_en <= 1'b1;
            synth_ctrl_pkg::MODE_LD_10NS:   o_lock_thresh_10ns <= 1'b1;
            default: ;
         endcase
      end
   end

   // Monitor mux; timer choices show high while counting
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         o_monitor_output <= 1'b0;
      end else begin
         case (mon_sel)
            synth_ctrl_pkg::MON_REF_DIV:   o_monitor_output <= i_ref_div_out;
            synth_ctrl_pkg::MON_INT_DIV:   o_monitor_output <= i_int_div_out;
            synth_ctrl_pkg::MON_PUMP_TMR:  o_monitor_output <= tmr_run[0];
            synth_ctrl_pkg::MON_SW_AB_TMR: o_monitor_output <= tmr_run[1];
            synth_ctrl_pkg::MON_SW_C_TMR:  o_monitor_output <= tmr_run[2];
            synth_ctrl_pkg::MON_LOCK:      o_monitor_output <= i_lock_detect;
            default:                       o_monitor_output <= 1'b0;
         endcase
      end
   end

   // Checks
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_resetn);

   // Apply cycle and the one-cycle load pulse that must follow it
   sequence s_apply_cycle;
      apply_pending && i_pd_tick;
   endsequence

   sequence s_load_pulse;
      o_divider_load && o_pump_current_step == 3'h6 ##1 !o_divider_load;
   endsequence

   a_loop_polarity: assert property (
      wr_loop |=> o_pd_polarity_pos == $past(i_word[3]) && o_pump_ground == !$past(i_word[5]))
      else $error("loop function bits not applied");

   a_timer_route: assert property (
      wr_fastlock && timer_sel == 2'h2 |=> load_val[0] == $past(timer_val)
      && $stable(load_val[1]) && $stable(load_val[2]))
      else $error("timer value routed to wrong counter");

   a_chan_apply: assert property (
      s_apply_cycle |=> s_load_pulse)
      else $error("channel write not applied on next detector cycle");

   a_switch_close: assert property (
      apply |=> o_switch_c_closed && o_switch_ab_closed)
      else $error("switches not closed at fast lock");

   a_switch_open: assert property (
      !apply && !tmr_run[2] |=> !o_switch_c_closed)
      else $error("switch c held after expiry");

   a_pump_ramp: assert property (
      !apply && tmr_run[0] |=> o_pump_current_step == $past(o_pump_current_step)
      || $past(o_pump_current_step) == 3'h0)
      else $error("pump current fell before timer expiry");

   a_amp_both: assert property (
      wr_power && i_word[7:6] == 2'h3 |=> o_amp_powerdown ##1 o_amp_powerdown)
      else $error("amplifier not powered down");

   a_pump_float: assert property (
      wr_power && i_word[4] |-> ##2 o_pump_tristate)
      else $error("pump outputs not floated");

   a_mode_dither: assert property (
      wr_mode && i_word[15:12] == 4'h3 |=> o_dither_en && $stable(o_lock_thresh_10ns))
      else $error("dither code not applied");

   a_monitor_timer: assert property (
      mon_sel == 4'h2 && !wr_mode |=> o_monitor_output == $past(tmr_run[0]))
      else $error("monitor does not follow pump timer");

   a_timer_start: assert property (
      s_apply_cycle |=> tmr_run[2] == ($past(load_val[2]) != '0)
      && tmr_run[1] == ($past(load_val[1]) != '0))
      else $error("timeout counters not started by channel write");

   a_hold_release: assert property (
      $fell(o_pll_powered_down) |-> $past(wr_channel) && $past(seen_phase) && $past(seen_modulus))
      else $error("power-up hold left without full word set");

   a_count_reset: assert property (
      wr_power |-> ##2 o_counter_reset == $past(i_word[3], 2))
      else $error("counter reset does not follow its bit");

   a_mode_default: assert property (
      wr_mode && i_word[15:12] == 4'h0 |=> !o_dither_en && !o_lock_thresh_10ns)
      else $error("default mode code not applied");

endmodule

// ===== verilog/synth_ctrl_pkg.sv
package synth_ctrl_pkg;

   // Word select codes, low three bits of every word
   localparam logic [2:0] SEL_CHANNEL  = 3'h0;
   localparam logic [2:0] SEL_MODULUS  = 3'h1;
   localparam logic [2:0] SEL_PHASE    = 3'h2;
   localparam logic [2:0] SEL_LOOP     = 3'h3;
   localparam logic [2:0] SEL_FASTLOCK = 3'h4;
   localparam logic [2:0] SEL_POWER    = 3'h5;
   localparam logic [2:0] SEL_MODE     = 3'h6;
   localparam int         SEL_LSB      = 0;

   // Loop function register fields
   localparam int POLARITY_BIT  = 3;
   localparam int PUMP_GND_N_BIT = 5;

   // Fast-lock timer register fields
   localparam int TIMER_SEL_LSB = 3;
   localparam int TIMER_VAL_LSB = 5;
   localparam int TIMER_VAL_W   = 9;
   localparam logic [1:0] TSEL_SWITCH_C  = 2'h0;
   localparam logic [1:0] TSEL_SWITCH_AB = 2'h1;
   localparam logic [1:0] TSEL_PUMP      = 2'h2;

   // Power-down register fields
   localparam int CNT_RESET_BIT = 3;
   localparam int TRISTATE_BIT  = 4;
   localparam int PUMP_PD_BIT   = 5;
   localparam int AMP_PD_LO_BIT = 6;
   localparam int AMP_PD_HI_BIT = 7;

   // Mode and monitor register fields
   localparam int MODE_LSB = 12;
   localparam int MON_LSB  = 3;
   localparam logic [3:0] MODE_DEFAULT   = 4'h0;
   localparam logic [3:0] MODE_DITHER_ON = 4'h3;
   localparam logic [3:0] MODE_LD_10NS   = 4'h9;
   localparam logic [3:0] MON_REF_DIV    = 4'h0;
   localparam logic [3:0] MON_INT_DIV    = 4'h1;
   localparam logic [3:0] MON_PUMP_TMR   = 4'h2;
   localparam logic [3:0] MON_SW_AB_TMR  = 4'h3;
   localparam logic [3:0] MON_SW_C_TMR   = 4'h4;
   localparam logic [3:0] MON_LOCK       = 4'h5;

   // Values after reset
   localparam logic [8:0] TIMER_RESET    = 9'h000;
   localparam logic [3:0] MON_RESET      = 4'h0;
   localparam logic [4:0] PD_RESET       = 5'h1F;

   // Timing counts
   localparam int         PD_PER_TICK    = 4;
   localparam logic [2:0] PUMP_STEP_MAX  = 3'h6;
   localparam int         NUM_TIMERS     = 3;
   localparam int         TMR_PUMP       = 0;
   localparam int         TMR_SW_AB      = 1;
   localparam int         TMR_SW_C       = 2;

endpackage

// ===== verilog/fastlock_timeout.sv
`timescale 1ns/10ps
// One fast-lock timeout counter, counting quarter-rate ticks
module fastlock_timeout #(
   parameter int WIDTH = 9
) (
   // Clock and reset
   input  wire logic             i_clk_sys,
   input  wire logic             i_resetn,
   // Control
   input  wire logic             i_start,
   input  wire logic             i_tick,
   input  wire logic [WIDTH-1:0] i_load_val,
   // Status
   output logic                  o_running
);

   logic [WIDTH-1:0] remain;

   // Load on start; a zero load never runs
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         remain    <= '0;
         o_running <= 1'b0;
      end else if (i_start) begin
         remain    <= i_load_val;
         o_running <= (i_load_val != '0);
      end else if (o_running && i_tick) begin
         remain    <= remain - WIDTH'(1);
         o_running <= (remain != WIDTH'(1));
      end
   end

endmodule

// ===== tb/host_word_writer.sv
`timescale 1ns/10ps
// Host side: formats finished words and hands them over one at a time
module host_word_writer (
   // Clock
   input  wire logic        i_clk_sys,
   // Word port toward the registers
   output logic [23:0]      o_word,
   output logic             o_word_load
);
   initial begin
      o_word      = 24'h000000;
      o_word_load = 1'b0;
   end

   // One-cycle load pulse; data scrambled once taken so stale bits never help
   task automatic send(input logic [23:0] w);
      @(posedge i_clk_sys);
      o_word      <= w;
      o_word_load <= 1'b1;
      @(posedge i_clk_sys);
      o_word      <= ~w;
      o_word_load <= 1'b0;
   endtask

   // Word builders keep every reserved field at its required value
   function automatic logic [23:0] loop_word(input logic pol, input logic gnd_n);
      return {8'h00, 10'h001, gnd_n, 1'b1, pol, synth_ctrl_pkg::SEL_LOOP};
   endfunction
   function automatic logic [23:0] timer_word(input logic [8:0] v, input logic [1:0] ts);
      return {10'h001, v, ts, synth_ctrl_pkg::SEL_FASTLOCK};
   endfunction
   function automatic logic [23:0] mode_word(input logic [3:0] m, input logic [3:0] mon);
      return {8'h00, m, 5'h00, mon, synth_ctrl_pkg::SEL_MODE};
   endfunction
   function automatic logic [23:0] power_word(input logic [4:0] p);
      return {16'h0000, p, synth_ctrl_pkg::SEL_POWER};
   endfunction
endmodule

// ===== tb/test_synth_control_registers.sv
`timescale 1ns/10ps
// Self-checking bench for the synthesizer control registers
module test_synth_control_registers;
   logic        i_clk_sys     = 1'b0;
   logic        i_resetn      = 1'b0;
   logic        i_pd_tick     = 1'b0;
   logic [3:0]  src_cnt       = 4'h0;
   logic [23:0] word;
   logic        word_load;
   logic        pump_ground, pol_pos, pll_pd, amp_pd, pump_pd, pump_tri;
   logic        div_hold, cnt_rst, ld_rst, div_load, sw_ab, sw_c, dither, thr10, mon_out;
   logic [2:0]  pump_step;
   logic [31:0] rng           = 32'h0000004D;
   int          num_errors    = 0;
   int          cmp_count     = 0;

   // Clock, detector tick every second clock, monitor sources from a counter
   always #2 i_clk_sys = ~i_clk_sys;
   always @(posedge i_clk_sys) begin
      i_pd_tick <= ~i_pd_tick;
      src_cnt   <= src_cnt + 4'h1;
   end

   host_word_writer host (.i_clk_sys(i_clk_sys), .o_word(word), .o_word_load(word_load));

   synth_control_registers DUT (
      .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_word(word), .i_word_load(word_load),
      .i_pd_tick(i_pd_tick), .i_ref_div_out(src_cnt[1]), .i_int_div_out(src_cnt[2]),
      .i_lock_detect(src_cnt[3]), .o_pump_ground(pump_ground), .o_pd_polarity_pos(pol_pos),
      .o_pll_powered_down(pll_pd), .o_amp_powerdown(amp_pd), .o_pump_powerdown(pump_pd),
      .o_pump_tristate(pump_tri), .o_divider_hold(div_hold), .o_counter_reset(cnt_rst),
      .o_lock_detect_reset(ld_rst), .o_divider_load(div_load), .o_pump_current_step(pump_step),
      .o_switch_ab_closed(sw_ab), .o_switch_c_closed(sw_c), .o_dither_en(dither),
      .o_lock_thresh_10ns(thr10), .o_monitor_output(mon_out));

   function automatic logic [31:0] rand_draw();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %0h seen %0h", what, exp, got);
      end
   endtask

   // Counts drift by the tick phase, so allow a few clocks either way
   task automatic near(input string what, input int exp, input int got);
      cmp_count++;
      if (got < exp - 6 || got > exp + 6) begin
         num_errors++;
         $display("unexpected %s: expected %0d seen %0d", what, exp, got);
      end
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge i_clk_sys);
      @(negedge i_clk_sys);
   endtask

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Watchdog well beyond the expected run length
   initial begin
      #200000;
      num_errors++;
      $display("unexpected hang: watchdog expired");
      conclude();
   end

   initial begin : main
      logic [4:0] p;
      logic       ea;
      logic [3:0] modes [6];
      logic [1:0] mexp [6];
      logic [3:0] mon;
      logic       prev;
      int         np, nab, nc, c_ab, c_c, c_pump, c_mon, c_load, mon_exp;
      modes = '{4'h0, 4'h9, 4'h0, 4'h3, 4'h5, 4'h0};
      mexp  = '{2'b00, 2'b01, 2'b00, 2'b10, 2'b10, 2'b00};
      repeat (4) @(posedge i_clk_sys);
      i_resetn <= 1'b1;
      @(negedge i_clk_sys);
      check("reset outputs", {16'h0000, 9'h1FF, 7'h00}, {16'h0000, pump_ground, pol_pos,
            pll_pd, amp_pd, pump_pd, pump_tri, div_hold, cnt_rst, ld_rst, pump_step, sw_ab,
            sw_c, dither, thr10});
      $display("test reset done");

      // Loop function: every polarity and ground combination
      for (int i = 0; i < 4; i++) begin
         host.send(host.loop_word(i[0], i[1]));
         settle(2);
         check("pump ground", !i[1], pump_ground);
         check("polarity", i[0], pol_pos);
      end
      $display("test loop function done");

      // Power-up hold needs phase and modulus before the channel word
      host.send(host.power_word(5'h00));
      host.send({21'h000000, synth_ctrl_pkg::SEL_CHANNEL});
      settle(6);
      check("held down", 1'b1, pll_pd);
      host.send({21'h000000, synth_ctrl_pkg::SEL_PHASE});
      host.send({21'h000000, synth_ctrl_pkg::SEL_MODULUS});
      host.send({21'h000000, synth_ctrl_pkg::SEL_CHANNEL});
      settle(6);
      check("released", 1'b0, pll_pd);
      $display("test power-up done");

      // Power bits: corners then random, amp bits hold on mixed values
      ea = 1'b0;
      for (int k = 0; k < 10; k++) begin
         p = (k == 0) ? 5'h1F : (k == 1) ? 5'h00 : 5'(rand_draw());
         if (p[4:3] == 2'b11)
            ea = 1'b1;
         else if (p[4:3] == 2'b00)
            ea = 1'b0;
         host.send(host.power_word(p));
         settle(3);
         check("amp", ea, amp_pd);
         check("pump pd", {4{p[2]}}, {pump_pd, div_hold, ld_rst, pump_tri & p[2]});
         check("tristate", p[1] | p[2], pump_tri);
         check("counter reset", p[0], cnt_rst);
      end
      host.send(host.power_word(5'h00));
      $display("test power bits done");

      // Mode codes, including one outside the listed set
      for (int k = 0; k < 6; k++) begin
         host.send(host.mode_word(modes[k], synth_ctrl_pkg::MON_REF_DIV));
         settle(2);
         check("dither and threshold", mexp[k], {dither, thr10});
      end
      // Monitor follows each source one cycle late; unknown code reads low
      for (int s = 0; s < 4; s++) begin
         mon = (s == 0) ? synth_ctrl_pkg::MON_REF_DIV : (s == 1) ? synth_ctrl_pkg::MON_INT_DIV :
               (s == 2) ? synth_ctrl_pkg::MON_LOCK : 4'hF;
         host.send(host.mode_word(4'h0, mon));
         settle(2);
         for (int t = 0; t < 12; t++) begin
            prev = (s == 0) ? src_cnt[1] : (s == 1) ? src_cnt[2] : (s == 2) ? src_cnt[3] : 1'b0;
            settle(1);
            check("monitor", prev, mon_out);
         end
      end
      $display("test modes done");

      // Fast lock runs with random counts; first run is restarted mid-way
      for (int it = 0; it < 4; it++) begin
         np  = (it == 0) ? 1 : 1 + int'(rand_draw() % 8);
         nab = np + 7;
         nc  = np + 3 + int'(rand_draw() % 8);
         mon = synth_ctrl_pkg::MON_PUMP_TMR + 4'(it % 3);
         mon_exp = (it % 3 == 0) ? np : (it % 3 == 1) ? nab : nc;
         host.send(host.mode_word(4'h0, mon));
         host.send(host.timer_word(9'(np), synth_ctrl_pkg::TSEL_PUMP));
         host.send(host.timer_word(9'(nab), synth_ctrl_pkg::TSEL_SWITCH_AB));
         host.send(host.timer_word(9'(nc), synth_ctrl_pkg::TSEL_SWITCH_C));
         host.send(host.timer_word(9'h001, 2'h3));
         host.send({10'h001, 9'h001, 2'h0, 3'h7});
         if (it == 0) begin
            host.send({21'h000000, synth_ctrl_pkg::SEL_CHANNEL});
            settle(20);
         end
         host.send({21'h000000, synth_ctrl_pkg::SEL_CHANNEL});
         {c_ab, c_c, c_pump, c_mon, c_load} = '0;
         for (int t = 0; t < 300; t++) begin
            settle(0);
            c_ab   += int'(sw_ab);
            c_c    += int'(sw_c);
            c_pump += int'(pump_step != 3'h0);
            c_mon  += int'(mon_out);
            c_load += int'(div_load);
            if (t == 4)
               check("fast lock start", {3'h6, 2'b11}, {pump_step, sw_ab, sw_c});
            @(posedge i_clk_sys);
         end
         check("divider load pulses", 1, c_load);
         near("switch ab time", 8 * nab, c_ab);
         near("switch c time", 8 * nc, c_c);
         near("pump step time", 8 * (np + 6), c_pump);
         near("monitor timer", 8 * mon_exp, c_mon);
         check("pump settled", 3'h0, pump_step);
      end
      $display("test fast lock done");
      conclude();
   end
endmodule
